// ==== core/dcss_pkg.sv ====
/*
 * dcss_pkg: shared types and constants of the drive command source selector.
 * Assumes a single 100 MHz clock and a synchronous active-low reset in every user.
 */
package dcss_pkg;

  // source selection codes, in the order 0..3 that software writes
  typedef enum logic [1:0] {
    DCSS_SRC_TERMINAL,
    DCSS_SRC_SERIAL,
    DCSS_SRC_AND,
    DCSS_SRC_OR
  } dcss_src_t;

  // one set of command bits, as seen on the terminals or in the serial word
  typedef struct packed {
    logic dir;
    logic [1:0] setup;
    logic [1:0] preset;
  } dcss_bits_t;

  // the selected outputs
  typedef struct packed {
    logic ccw;
    logic [2:0] setup_num;
    logic [2:0] preset_num;
  } dcss_sel_t;

  localparam int DCSS_ADDR_W = 8;
  localparam int DCSS_DATA_W = 32;
  localparam int DCSS_SYNC_STAGES = 2;

  localparam logic [DCSS_ADDR_W-1:0] DCSS_DIR_SRC_OFS = 8'h00;
  localparam logic [DCSS_ADDR_W-1:0] DCSS_SETUP_SRC_OFS = 8'h04;
  localparam logic [DCSS_ADDR_W-1:0] DCSS_PRESET_SRC_OFS = 8'h08;
  localparam logic [DCSS_ADDR_W-1:0] DCSS_STATUS_OFS = 8'h0C;

  localparam int DCSS_SRC_LSB = 0;
  localparam int DCSS_ST_CCW_BIT = 0;
  localparam int DCSS_ST_SETUP_LSB = 4;
  localparam int DCSS_ST_PRESET_LSB = 8;
  localparam int DCSS_ST_TERM_LSB = 16;
  localparam int DCSS_ST_SER_LSB = 24;

  localparam dcss_src_t DCSS_DIR_SRC_RST = DCSS_SRC_TERMINAL;
  localparam dcss_src_t DCSS_SETUP_SRC_RST = DCSS_SRC_OR;
  localparam dcss_src_t DCSS_PRESET_SRC_RST = DCSS_SRC_OR;
  localparam logic [2:0] DCSS_NUM_RST = 3'h1;
  localparam logic [2:0] DCSS_NUM_MAX = 3'h4;

endpackage : dcss_pkg

// ==== core/dcss_sync.sv ====
/*
 * dcss_sync: two-flop level synchroniser for a bundle of unrelated pin levels.
 * Assumes each bit is a slow level; bits are not guaranteed to cross together.
 */
`timescale 1ns/100ps
`default_nettype none
module dcss_sync #(
  parameter int W = 1
) (
  input wire logic clk, // system clock
  input wire logic rstn, // synchronous reset, active low
  input wire logic [W-1:0] async_in, // levels from outside the clock domain
  output logic [W-1:0] sync_out // levels after two flops
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  if (W < 1) begin : g_bad_width
    $error("dcss_sync: W must be at least 1");
  end

  // the first stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (!rstn) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;
endmodule : dcss_sync
`default_nettype wire

// ==== core/dcss_combine.sv ====
/*
 * dcss_combine: merges terminal and serial values under one source code.
 * Assumes both inputs are already in the clock domain; purely combinational.
 */
`timescale 1ns/100ps
`default_nettype none
module dcss_combine #(
  parameter int W = 1
) (
  input wire dcss_pkg::dcss_src_t mode, // source selection code
  input wire logic [W-1:0] term, // terminal value
  input wire logic [W-1:0] ser, // serial link value
  output logic [W-1:0] comb // combined value
);
  import dcss_pkg::*;

  if (W < 1) begin : g_bad_width
    $error("dcss_combine: W must be at least 1");
  end

  // all four codes are legal, so no default arm
  always_comb begin
    unique case (mode)
      DCSS_SRC_TERMINAL: comb = term;
      DCSS_SRC_SERIAL: comb = ser;
      DCSS_SRC_AND: comb = term & ser;
      DCSS_SRC_OR: comb = term | ser;
    endcase
  end
endmodule : dcss_combine
`default_nettype wire

// ==== core/dcss_top.sv ====
/*
 * dcss_top: drive command source selector with its configuration registers.
 * Assumes terminal pins are asynchronous levels, serial control-word bits come
 * from logic on clk, and the register master follows the plain strobe protocol.
 */
// The placing of the registers and strobed register access are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module dcss_top (
  input wire logic clk, // system clock, 100 MHz
  input wire logic rstn, // synchronous reset, active low
  input wire dcss_pkg::dcss_bits_t term_pins, // terminal levels, asynchronous
  input wire dcss_pkg::dcss_bits_t ser_bits, // serial control-word bits, on clk
  input wire logic [dcss_pkg::DCSS_ADDR_W-1:0] reg_addr, // register byte address
  input wire logic [dcss_pkg::DCSS_DATA_W-1:0] reg_wdata, // register write data
  input wire logic reg_we, // write strobe, one cycle
  input wire logic reg_re, // read strobe, one cycle
  output logic [dcss_pkg::DCSS_DATA_W-1:0] reg_rdata, // read data, cycle after strobe
  output dcss_pkg::dcss_sel_t sel_out // selected direction, setup, preset
);
  import dcss_pkg::*;

  dcss_src_t direction_source_cfg_q;
  dcss_src_t setup_source_cfg_q;
  dcss_src_t preset_source_cfg_q;
  dcss_bits_t term_s;
  logic comb_dir;
  logic [1:0] comb_setup;
  logic [1:0] comb_preset;
  dcss_sel_t sel_d;
  dcss_sel_t sel_q;
  logic [DCSS_DATA_W-1:0] rdata_d;
  logic [DCSS_DATA_W-1:0] rdata_q;

  // pins are slow levels; the two-flop delay is negligible against drive response
  dcss_sync #(
    .W($bits(dcss_bits_t))
  ) u_term_sync (
    .clk(clk),
    .rstn(rstn),
    .async_in(term_pins),
    .sync_out(term_s)
  );

  // configuration registers; writes to other offsets are dropped
  always_ff @(posedge clk) begin
    if (!rstn) begin
      direction_source_cfg_q <= DCSS_DIR_SRC_RST;
    end else if (reg_we && reg_addr == DCSS_DIR_SRC_OFS) begin
      direction_source_cfg_q <= dcss_src_t'(reg_wdata[DCSS_SRC_LSB +: 2]);
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      setup_source_cfg_q <= DCSS_SETUP_SRC_RST;
    end else if (reg_we && reg_addr == DCSS_SETUP_SRC_OFS) begin
      setup_source_cfg_q <= dcss_src_t'(reg_wdata[DCSS_SRC_LSB +: 2]);
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      preset_source_cfg_q <= DCSS_PRESET_SRC_RST;
    end else if (reg_we && reg_addr == DCSS_PRESET_SRC_OFS) begin
      preset_source_cfg_q <= dcss_src_t'(reg_wdata[DCSS_SRC_LSB +: 2]);
    end
  end

  // one combiner per function keeps the scheme identical across all of them
  dcss_combine #(
    .W(1)
  ) u_dir_comb (
    .mode(direction_source_cfg_q),
    .term(term_s.dir),
    .ser(ser_bits.dir),
    .comb(comb_dir)
  );

  dcss_combine #(
    .W(2)
  ) u_setup_comb (
    .mode(setup_source_cfg_q),
    .term(term_s.setup),
    .ser(ser_bits.setup),
    .comb(comb_setup)
  );

  dcss_combine #(
    .W(2)
  ) u_preset_comb (
    .mode(preset_source_cfg_q),
    .term(term_s.preset),
    .ser(ser_bits.preset),
    .comb(comb_preset)
  );

  // numbers run 1..4, so the plus one never overflows three bits
  always_comb begin
    sel_d.ccw = comb_dir;
    sel_d.setup_num = {1'b0, comb_setup} + 3'h1;
    sel_d.preset_num = {1'b0, comb_preset} + 3'h1;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      sel_q.ccw <= 1'b0;
      sel_q.setup_num <= DCSS_NUM_RST;
      sel_q.preset_num <= DCSS_NUM_RST;
    end else begin
      sel_q <= sel_d;
    end
  end

  assign sel_out = sel_q;

  // read mux; unmapped offsets read zero
  always_comb begin
    rdata_d = '0;
    if (reg_re) begin
      unique case (reg_addr)
        DCSS_DIR_SRC_OFS: rdata_d[DCSS_SRC_LSB +: 2] = direction_source_cfg_q;
        DCSS_SETUP_SRC_OFS: rdata_d[DCSS_SRC_LSB +: 2] = setup_source_cfg_q;
        DCSS_PRESET_SRC_OFS: rdata_d[DCSS_SRC_LSB +: 2] = preset_source_cfg_q;
        DCSS_STATUS_OFS: begin
          rdata_d[DCSS_ST_CCW_BIT] = sel_q.ccw;
          rdata_d[DCSS_ST_SETUP_LSB +: 3] = sel_q.setup_num;
          rdata_d[DCSS_ST_PRESET_LSB +: 3] = sel_q.preset_num;
          rdata_d[DCSS_ST_TERM_LSB +: 5] = term_s;
          rdata_d[DCSS_ST_SER_LSB +: 5] = ser_bits;
        end
        default: rdata_d = '0;
      endcase
    end
  end

  // data stand only in the cycle after the strobe, zero otherwise
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

  // helper: cycles since reset release, saturating, so $past depths are valid
  logic [2:0] warm_q;
  always_ff @(posedge clk) begin
    if (!rstn) begin
      warm_q <= 3'h0;
    end else if (warm_q != 3'h4) begin
      warm_q <= warm_q + 3'h1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  cfg_write_a: assert property (
    reg_we && reg_addr == DCSS_DIR_SRC_OFS |=>
      direction_source_cfg_q == dcss_src_t'($past(reg_wdata[1:0])))
    else $error("direction source code not stored");

  dir_cfg_rst_a: assert property (disable iff (1'b0)
    !rstn |=> direction_source_cfg_q == DCSS_SRC_TERMINAL)
    else $error("direction source not terminal after reset");

  dir_terminal_a: assert property (
    warm_q == 3'h4 && $past(direction_source_cfg_q) == DCSS_SRC_TERMINAL &&
      $past(direction_source_cfg_q, 2) == DCSS_SRC_TERMINAL &&
      $past(direction_source_cfg_q, 3) == DCSS_SRC_TERMINAL |->
      sel_q.ccw == $past(term_pins.dir, 3))
    else $error("direction does not follow terminal pin");

  dir_serial_a: assert property (
    warm_q != 3'h0 && $past(direction_source_cfg_q) == DCSS_SRC_SERIAL |->
      sel_q.ccw == $past(ser_bits.dir))
    else $error("direction does not follow serial bit");

  dir_and_a: assert property (
    warm_q != 3'h0 && $past(direction_source_cfg_q) == DCSS_SRC_AND |->
      sel_q.ccw == ($past(term_s.dir) && $past(ser_bits.dir)))
    else $error("direction and combination wrong");

  dir_or_a: assert property (
    warm_q != 3'h0 && $past(direction_source_cfg_q) == DCSS_SRC_OR |->
      sel_q.ccw == ($past(term_s.dir) || $past(ser_bits.dir)))
    else $error("direction or combination wrong");

  sel_cfg_rst_a: assert property (disable iff (1'b0)
    !rstn |=> setup_source_cfg_q == DCSS_SRC_OR && preset_source_cfg_q == DCSS_SRC_OR)
    else $error("setup or preset source not or after reset");

  num_range_a: assert property (
    sel_q.setup_num >= 3'h1 && sel_q.setup_num <= DCSS_NUM_MAX &&
      sel_q.preset_num >= 3'h1 && sel_q.preset_num <= DCSS_NUM_MAX)
    else $error("selected number outside one to four");

  setup_terminal_a: assert property (
    warm_q != 3'h0 && $past(setup_source_cfg_q) == DCSS_SRC_TERMINAL |->
      sel_q.setup_num == {1'b0, $past(term_s.setup)} + 3'h1)
    else $error("setup number not terminal plus one");

  preset_serial_a: assert property (
    warm_q != 3'h0 && $past(preset_source_cfg_q) == DCSS_SRC_SERIAL |->
      sel_q.preset_num == {1'b0, $past(ser_bits.preset)} + 3'h1)
    else $error("preset number not serial plus one");

  setup_and_a: assert property (
    warm_q != 3'h0 && $past(setup_source_cfg_q) == DCSS_SRC_AND |->
      sel_q.setup_num == {1'b0, $past(term_s.setup) & $past(ser_bits.setup)} + 3'h1)
    else $error("setup and combination wrong");

  preset_or_a: assert property (
    warm_q != 3'h0 && $past(preset_source_cfg_q) == DCSS_SRC_OR |->
      sel_q.preset_num == {1'b0, $past(term_s.preset) | $past(ser_bits.preset)} + 3'h1)
    else $error("preset or combination wrong");

  sel_rst_a: assert property (disable iff (1'b0)
    !rstn |=> sel_q.ccw == 1'b0 && sel_q.setup_num == DCSS_NUM_RST &&
      sel_q.preset_num == DCSS_NUM_RST)
    else $error("outputs not clockwise and one after reset");

  // writes land only at their own offset; everything else leaves the codes alone
  setup_write_a: assert property (
    reg_we && reg_addr == DCSS_SETUP_SRC_OFS |=>
      setup_source_cfg_q == dcss_src_t'($past(reg_wdata[1:0])))
    else $error("setup source code not stored");

  preset_write_a: assert property (
    reg_we && reg_addr == DCSS_PRESET_SRC_OFS |=>
      preset_source_cfg_q == dcss_src_t'($past(reg_wdata[1:0])))
    else $error("preset source code not stored");

  cfg_hold_a: assert property (
    !reg_we |=> $stable(direction_source_cfg_q) && $stable(setup_source_cfg_q) &&
      $stable(preset_source_cfg_q))
    else $error("source code changed without a write");

  stray_write_a: assert property (
    reg_we && reg_addr != DCSS_DIR_SRC_OFS && reg_addr != DCSS_SETUP_SRC_OFS &&
      reg_addr != DCSS_PRESET_SRC_OFS |=> $stable(direction_source_cfg_q) &&
      $stable(setup_source_cfg_q) && $stable(preset_source_cfg_q))
    else $error("write to another offset changed a source code");

  // read data answer once, in the cycle after the strobe, and are zero otherwise
  rdata_idle_a: assert property (
    !reg_re |=> reg_rdata == '0)
    else $error("read data not zero outside the answer cycle");

  rd_dir_a: assert property (
    reg_re && reg_addr == DCSS_DIR_SRC_OFS |=> reg_rdata[DCSS_DATA_W-1:2] == '0 &&
      reg_rdata[1:0] == $past(direction_source_cfg_q))
    else $error("direction source code read back wrong");

  rd_setup_a: assert property (
    reg_re && reg_addr == DCSS_SETUP_SRC_OFS |=> reg_rdata[DCSS_DATA_W-1:2] == '0 &&
      reg_rdata[1:0] == $past(setup_source_cfg_q))
    else $error("setup source code read back wrong");

  rd_preset_a: assert property (
    reg_re && reg_addr == DCSS_PRESET_SRC_OFS |=> reg_rdata[DCSS_DATA_W-1:2] == '0 &&
      reg_rdata[1:0] == $past(preset_source_cfg_q))
    else $error("preset source code read back wrong");

  rd_unmapped_a: assert property (
    reg_re && reg_addr != DCSS_DIR_SRC_OFS && reg_addr != DCSS_SETUP_SRC_OFS &&
      reg_addr != DCSS_PRESET_SRC_OFS && reg_addr != DCSS_STATUS_OFS |=> reg_rdata == '0)
    else $error("read of an unmapped offset not zero");

  rd_status_a: assert property (
    reg_re && reg_addr == DCSS_STATUS_OFS |=>
      reg_rdata[DCSS_ST_CCW_BIT] == $past(sel_q.ccw) &&
      reg_rdata[DCSS_ST_SETUP_LSB +: 3] == $past(sel_q.setup_num) &&
      reg_rdata[DCSS_ST_PRESET_LSB +: 3] == $past(sel_q.preset_num))
    else $error("status read does not show the selection");

  rd_inputs_a: assert property (
    reg_re && reg_addr == DCSS_STATUS_OFS |=>
      reg_rdata[DCSS_ST_TERM_LSB +: 5] == $past(term_s) &&
      reg_rdata[DCSS_ST_SER_LSB +: 5] == $past(ser_bits))
    else $error("status read does not show the inputs");

  // the terminal path is exactly two flops long
  sync_delay_a: assert property (
    warm_q >= 3'h2 |-> term_s == $past(term_pins, 2))
    else $error("terminal levels not two cycles behind the pins");

  // serial mode: a terminal edge alone must never move a selection
  dir_term_ignored_a: assert property (
    warm_q >= 3'h2 && $past(direction_source_cfg_q) == DCSS_SRC_SERIAL &&
      $past(direction_source_cfg_q, 2) == DCSS_SRC_SERIAL &&
      $past(ser_bits.dir) == $past(ser_bits.dir, 2) |-> $stable(sel_q.ccw))
    else $error("direction moved with the terminal in serial mode");

  setup_term_ignored_a: assert property (
    warm_q >= 3'h2 && $past(setup_source_cfg_q) == DCSS_SRC_SERIAL &&
      $past(setup_source_cfg_q, 2) == DCSS_SRC_SERIAL &&
      $past(ser_bits.setup) == $past(ser_bits.setup, 2) |-> $stable(sel_q.setup_num))
    else $error("setup number moved with the terminal in serial mode");

  dir_need_term_a: assert property (
    warm_q != 3'h0 && $past(direction_source_cfg_q) == DCSS_SRC_AND &&
      !$past(term_s.dir) |-> !sel_q.ccw)
    else $error("and mode turned without the terminal");

  setup_serial_a: assert property (
    warm_q != 3'h0 && $past(setup_source_cfg_q) == DCSS_SRC_SERIAL |->
      sel_q.setup_num == {1'b0, $past(ser_bits.setup)} + 3'h1)
    else $error("setup number not serial plus one");

  preset_terminal_a: assert property (
    warm_q != 3'h0 && $past(preset_source_cfg_q) == DCSS_SRC_TERMINAL |->
      sel_q.preset_num == {1'b0, $past(term_s.preset)} + 3'h1)
    else $error("preset number not terminal plus one");

  preset_and_a: assert property (
    warm_q != 3'h0 && $past(preset_source_cfg_q) == DCSS_SRC_AND |->
      sel_q.preset_num == {1'b0, $past(term_s.preset) & $past(ser_bits.preset)} + 3'h1)
    else $error("preset and combination wrong");

  setup_or_a: assert property (
    warm_q != 3'h0 && $past(setup_source_cfg_q) == DCSS_SRC_OR |->
      sel_q.setup_num == {1'b0, $past(term_s.setup) | $past(ser_bits.setup)} + 3'h1)
    else $error("setup or combination wrong");

endmodule : dcss_top
`default_nettype wire

// ==== bench/dcss_far_side.sv ====
/*
 * dcss_far_side: model of the terminals and the serial master feeding the selector.
 * Assumes the bench commands levels on clk; terminals settle off the clock edge.
 */
`timescale 1ns/100ps
`default_nettype none
module dcss_far_side (
  input wire logic clk, // system clock
  input wire dcss_pkg::dcss_bits_t term_req, // wanted terminal levels
  input wire dcss_pkg::dcss_bits_t ser_req, // wanted control-word bits
  output dcss_pkg::dcss_bits_t term_pins, // terminal levels
  output dcss_pkg::dcss_bits_t ser_bits // control-word bits
);
  import dcss_pkg::*;
  // terminals move 3 ns after the request, unrelated to the edge itself
  // a continuous assignment also carries the initial levels, so the pins are unknown only for the first 3 ns
  assign #3 term_pins = term_req;
  // serial word lands one edge later, as a word received by the master would
  always_ff @(posedge clk) begin
    ser_bits <= ser_req;
  end
endmodule : dcss_far_side
`default_nettype wire

// ==== bench/testbench.sv ====
/*
 * testbench: self-checking scenarios for the command source selector.
 * Assumes dcss_top and dcss_far_side; one 100 MHz clock, no random stimulus.
 */
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import dcss_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  dcss_bits_t term_req = '0;
  dcss_bits_t ser_req = '0;
  dcss_bits_t term_pins;
  dcss_bits_t ser_bits;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_we = 1'b0;
  logic reg_re = 1'b0;
  logic [31:0] reg_rdata;
  dcss_sel_t sel_out;
  int errors = 0;
  int comparisons = 0;

  always #5 clk = ~clk;

  dcss_far_side dcss_far_side_i (.clk(clk), .term_req(term_req), .ser_req(ser_req),
    .term_pins(term_pins), .ser_bits(ser_bits));
  dcss_top dcss_top_i (.clk(clk), .rstn(rstn), .term_pins(term_pins), .ser_bits(ser_bits),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
    .reg_rdata(reg_rdata), .sel_out(sel_out));

  task automatic complete_run;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (exp !== got) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_we <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_re <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd

  // far side adds one edge on the serial path, terminals need three through sync
  task automatic apply(input dcss_bits_t t, input dcss_bits_t s);
    @(posedge clk);
    term_req <= t;
    ser_req <= s;
    repeat (4) @(posedge clk);
    #1;
  endtask : apply

  function automatic logic [1:0] mix(input int code, input logic [1:0] t, input logic [1:0] s);
    case (code)
      0: return t;
      1: return s;
      2: return t & s;
      default: return t | s;
    endcase
  endfunction : mix

  task automatic reset_defaults;
    logic [31:0] d;
    chk("ccw", 32'h0, sel_out.ccw);
    chk("setup_num", 32'h1, sel_out.setup_num);
    chk("preset_num", 32'h1, sel_out.preset_num);
    rd(DCSS_DIR_SRC_OFS, d);
    chk("direction_source_cfg", 32'h0, d);
    rd(DCSS_SETUP_SRC_OFS, d);
    chk("setup_source_cfg", 32'h3, d);
    rd(DCSS_PRESET_SRC_OFS, d);
    chk("preset_source_cfg", 32'h3, d);
  endtask : reset_defaults

  task automatic direction_codes;
    dcss_bits_t t;
    dcss_bits_t s;
    for (int c = 0; c < 4; c++) begin
      wr(DCSS_DIR_SRC_OFS, c);
      for (int v = 0; v < 4; v++) begin
        t = '0;
        s = '0;
        t.dir = v[1];
        s.dir = v[0];
        apply(t, s);
        chk("ccw", {31'h0, mix(c, {1'b0, t.dir}, {1'b0, s.dir}) != 2'h0}, sel_out.ccw);
      end
    end
  endtask : direction_codes

  // preset uses the mirrored code and swapped values, so the two paths cannot alias
  task automatic number_codes;
    dcss_bits_t t;
    dcss_bits_t s;
    for (int c = 0; c < 4; c++) begin
      wr(DCSS_SETUP_SRC_OFS, c);
      wr(DCSS_PRESET_SRC_OFS, 3 - c);
      for (int v = 0; v < 16; v++) begin
        t = '0;
        s = '0;
        t.setup = v[3:2];
        s.setup = v[1:0];
        t.preset = v[1:0];
        s.preset = v[3:2];
        apply(t, s);
        chk("setup_num", {29'h0, {1'b0, mix(c, v[3:2], v[1:0])} + 3'h1}, sel_out.setup_num);
        chk("preset_num", {29'h0, {1'b0, mix(3 - c, v[1:0], v[3:2])} + 3'h1}, sel_out.preset_num);
      end
    end
  endtask : number_codes

  task automatic register_edges;
    logic [31:0] d;
    wr(DCSS_DIR_SRC_OFS, 32'hFFFF_FFF1);
    rd(DCSS_DIR_SRC_OFS, d);
    chk("direction_source_cfg", 32'h1, d);
    wr(DCSS_STATUS_OFS, 32'hFFFF_FFFF);
    wr(8'h40, 32'h2);
    rd(8'h40, d);
    chk("unmapped", 32'h0, d);
    // preset code is terminal here; the stray writes above would have changed it
    rd(DCSS_PRESET_SRC_OFS, d);
    chk("preset_source_cfg", 32'h0, d);
    // direction serial 0, setup or of 01 and 10 gives 4, preset terminal 01 gives 2
    apply(5'h15, 5'h0A);
    rd(DCSS_STATUS_OFS, d);
    chk("status sel", 32'h0000_0240, d & 32'h0000_07FF);
    chk("status terminal", 32'h15, d[20:16]);
    chk("status serial", 32'h0A, d[28:24]);
    // a second reset mid-run must bring back the defaults
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    apply(5'h0, 5'h0);
    reset_defaults();
  endtask : register_edges

  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    complete_run();
  end

  initial begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    #1;
    reset_defaults();
    direction_codes();
    number_codes();
    register_edges();
    complete_run();
  end
endmodule : testbench
`default_nettype wire
